// ---- src/bif_defs.vh ----
// Shared constants for the board interrupt funnel
`ifndef BIF_DEFS_VH
`define BIF_DEFS_VH

// Resolver priority modes
`define BIF_MODE_NESTED   2'h0
`define BIF_MODE_ROTATE   2'h1
`define BIF_MODE_SPECIFIC 2'h2

// Reset values
`define BIF_RST_MODE      2'h0
`define BIF_RST_LOWEST    3'h7
`define BIF_RST_PMASK     8'h00
`define BIF_RST_CMASK     4'h0

// Shared RAM base as seen by the on-board processor
`define BIF_CPU_RAM_BASE  16'h8000

// Handler addresses per processor input
`define BIF_VEC_TRAP      16'h0024
`define BIF_VEC_R75       16'h003c
`define BIF_VEC_R65       16'h0034
`define BIF_VEC_R55       16'h002c
`define BIF_VEC_GEN       16'h0038
`define BIF_VEC_NONE      16'h0000

// Bit positions in the processor mask input
`define BIF_CM_R75        3
`define BIF_CM_R65        2
`define BIF_CM_R55        1
`define BIF_CM_GEN        0

`endif

// ---- src/bif_resolver.v ----
// Circular priority pick among eight request levels
`timescale 1ns/1ps
`default_nettype none

module bif_resolver #(
	parameter N  = 8,
	parameter LW = 3
) (
	input  wire [N-1:0]  req_i,
	input  wire [LW-1:0] lowest_i,
	output reg           valid_o,
	output reg  [LW-1:0] level_o
);

	// Scan from the level after the lowest, wrapping around
	function [LW:0] pick;
		input [N-1:0]  req;
		input [LW-1:0] low;
		integer        k;
		reg     [LW-1:0] idx;
		reg              hit;
		begin
			hit = 1'b0;
			pick = {1'b0, {LW{1'b0}}};
			idx = low;
			for (k = 0; k < N; k = k + 1) begin
				idx = idx + {{(LW-1){1'b0}}, 1'b1};
				if (!hit && req[idx]) begin
					hit = 1'b1;
					pick = {1'b1, idx};
				end
			end
		end
	endfunction

	// Winner decode
	always @* begin
		{valid_o, level_o} = pick(req_i, lowest_i);
	end

endmodule

`default_nettype wire

// ---- src/bif_top.v ----
// Interrupt gathering logic for the communications slave board
`timescale 1ns/1ps
`default_nettype none
`include "bif_defs.vh"

module bif_top #(
	parameter NREQ = 8,
	parameter NPORT = 4,
	parameter AW = 20
) (
	input  wire             sys_clk_i,
	input  wire             srst_i,
	input  wire [NREQ-1:0]  chan_req_i,
	input  wire             pr_cfg_wr_i,
	input  wire [1:0]       pr_mode_i,
	input  wire [2:0]       pr_lowest_i,
	input  wire [NREQ-1:0]  pr_mask_i,
	input  wire             pr_ack_i,
	input  wire             pr_eoi_i,
	output reg  [2:0]       pr_level_o,
	output reg              general_irq_input_o,
	input  wire [AW-1:0]    board_base_i,
	input  wire             sys_wr_i,
	input  wire [AW-1:0]    sys_addr_i,
	input  wire             cpu_rd_i,
	input  wire [15:0]      cpu_addr_i,
	output reg              flag_irq_o,
	input  wire [NPORT-1:0] carrier_i,
	input  wire [NPORT-1:0] ring_i,
	input  wire             line_clr_i,
	input  wire [NPORT-1:0] carrier_clr_i,
	input  wire [NPORT-1:0] ring_clr_i,
	output reg  [NPORT-1:0] carrier_lost_o,
	output reg  [NPORT-1:0] ring_seen_o,
	input  wire             timer6_i,
	input  wire             sys_irq_i,
	input  wire             sys_irq_set_i,
	input  wire             sys_irq_clr_i,
	output reg              sys_irq_o,
	input  wire             cpu_mask_wr_i,
	input  wire [3:0]       cpu_mask_i,
	output reg              cpu_trap_o,
	output reg              cpu_r75_o,
	output reg              cpu_r65_o,
	output reg              cpu_r55_o,
	output reg              cpu_gen_o,
	output reg  [15:0]      cpu_vec_o
);

	reg  [1:0]       mode_q;
	reg  [2:0]       low_q;
	reg  [NREQ-1:0]  pmask_q;
	reg  [3:0]       cmask_q;
	reg  [2:0]       serv_q;
	reg              busy_q;
	reg  [NPORT-1:0] carrier_q;
	reg  [NPORT-1:0] ring_q;
	wire             win_valid;
	wire [2:0]       win_level;
	reg  [2:0]       eff_low;
	wire [NREQ-1:0]  live_req;
	wire             flag_set;
	wire             flag_clr;
	wire [NPORT-1:0] carrier_fall;
	wire [NPORT-1:0] ring_rise;
	wire             line_any;
	reg              gen_d;

	// Pending levels are the raw request levels minus masked ones
	assign live_req = chan_req_i & ~pmask_q;

	// Lowest level per mode: nested forces level 7 lowest
	always @* begin
		case (mode_q)
			`BIF_MODE_NESTED:   eff_low = `BIF_RST_LOWEST;
			`BIF_MODE_ROTATE:   eff_low = low_q;
			`BIF_MODE_SPECIFIC: eff_low = low_q;
			default:            eff_low = `BIF_RST_LOWEST;
		endcase
	end

	bif_resolver #(
		.N  (NREQ),
		.LW (3)
	) u_res (
		.req_i    (live_req),
		.lowest_i (eff_low),
		.valid_o  (win_valid),
		.level_o  (win_level)
	);

	// Resolver configuration and service tracking
	always @(posedge sys_clk_i) begin
		if (srst_i) begin
			mode_q  <= `BIF_RST_MODE;
			low_q   <= `BIF_RST_LOWEST;
			pmask_q <= `BIF_RST_PMASK;
			serv_q  <= 3'h0;
			busy_q  <= 1'b0;
		end else begin
			if (pr_cfg_wr_i) begin
				mode_q  <= pr_mode_i;
				pmask_q <= pr_mask_i;
				if (pr_mode_i == `BIF_MODE_SPECIFIC) begin
					low_q <= pr_lowest_i;
				end
			end else if (pr_eoi_i && busy_q) begin
				busy_q <= 1'b0;
				if (mode_q == `BIF_MODE_ROTATE) begin
					low_q <= serv_q;
				end
			end else if (pr_ack_i && win_valid && !busy_q) begin
				serv_q <= win_level;
				busy_q <= 1'b1;
			end
		end
	end

	// Single combined request to the processor
	always @* begin
		gen_d = win_valid & ~busy_q;
	end

	always @(posedge sys_clk_i) begin
		if (srst_i) begin
			general_irq_input_o <= 1'b0;
			pr_level_o          <= 3'h0;
		end else begin
			general_irq_input_o <= gen_d;
			pr_level_o          <= busy_q ? serv_q : win_level;
		end
	end

	// Mailbox flag: set by bus write at this board's base, set wins
	assign flag_set = sys_wr_i && (sys_addr_i == board_base_i);
	assign flag_clr = cpu_rd_i && (cpu_addr_i == `BIF_CPU_RAM_BASE);

	always @(posedge sys_clk_i) begin
		if (srst_i) begin
			flag_irq_o <= 1'b0;
		end else if (flag_set) begin
			flag_irq_o <= 1'b1;
		end else if (flag_clr) begin
			flag_irq_o <= 1'b0;
		end
	end

	// Carrier loss and ring edges, sticky until cleared
	assign carrier_fall = carrier_q & ~carrier_i;
	assign ring_rise    = ring_i & ~ring_q;
	assign line_any     = |{carrier_lost_o, ring_seen_o};

	always @(posedge sys_clk_i) begin
		if (srst_i) begin
			carrier_q      <= {NPORT{1'b0}};
			ring_q         <= {NPORT{1'b0}};
			carrier_lost_o <= {NPORT{1'b0}};
			ring_seen_o    <= {NPORT{1'b0}};
		end else begin
			carrier_q <= carrier_i;
			ring_q    <= ring_i;
			carrier_lost_o <= carrier_fall |
				(carrier_lost_o & ~({NPORT{line_clr_i}} & carrier_clr_i));
			ring_seen_o <= ring_rise |
				(ring_seen_o & ~({NPORT{line_clr_i}} & ring_clr_i));
		end
	end

	// Bus interrupt out, set wins over clear
	always @(posedge sys_clk_i) begin
		if (srst_i) begin
			sys_irq_o <= 1'b0;
		end else if (sys_irq_set_i) begin
			sys_irq_o <= 1'b1;
		end else if (sys_irq_clr_i) begin
			sys_irq_o <= 1'b0;
		end
	end

	// Processor input mask, nonmaskable line excluded
	always @(posedge sys_clk_i) begin
		if (srst_i) begin
			cmask_q <= `BIF_RST_CMASK;
		end else if (cpu_mask_wr_i) begin
			cmask_q <= cpu_mask_i;
		end
	end

	// Five processor inputs and the handler address of the top one
	always @(posedge sys_clk_i) begin
		if (srst_i) begin
			cpu_trap_o <= 1'b0;
			cpu_r75_o  <= 1'b0;
			cpu_r65_o  <= 1'b0;
			cpu_r55_o  <= 1'b0;
			cpu_gen_o  <= 1'b0;
			cpu_vec_o  <= `BIF_VEC_NONE;
		end else begin
			cpu_trap_o <= sys_irq_i;
			cpu_r75_o  <= timer6_i & ~cmask_q[`BIF_CM_R75];
			cpu_r65_o  <= flag_irq_o & ~cmask_q[`BIF_CM_R65];
			cpu_r55_o  <= line_any & ~cmask_q[`BIF_CM_R55];
			cpu_gen_o  <= gen_d & ~cmask_q[`BIF_CM_GEN];
			if (sys_irq_i) begin
				cpu_vec_o <= `BIF_VEC_TRAP;
			end else if (timer6_i && !cmask_q[`BIF_CM_R75]) begin
				cpu_vec_o <= `BIF_VEC_R75;
			end else if (flag_irq_o && !cmask_q[`BIF_CM_R65]) begin
				cpu_vec_o <= `BIF_VEC_R65;
			end else if (line_any && !cmask_q[`BIF_CM_R55]) begin
				cpu_vec_o <= `BIF_VEC_R55;
			end else if (gen_d && !cmask_q[`BIF_CM_GEN]) begin
				cpu_vec_o <= `BIF_VEC_GEN;
			end else begin
				cpu_vec_o <= `BIF_VEC_NONE;
			end
		end
	end

endmodule

`default_nettype wire

// ---- verification/bif_chk.sv ----
// Port checks for the interrupt funnel
`timescale 1ns/1ps
`default_nettype none
`include "bif_defs.vh"

module bif_chk (
	input wire logic        sys_clk_i,
	input wire logic        srst_i,
	input wire logic [7:0]  chan_req_i,
	input wire logic        pr_cfg_wr_i,
	input wire logic        pr_ack_i,
	input wire logic        pr_eoi_i,
	input wire logic        general_irq_input_o,
	input wire logic [19:0] board_base_i,
	input wire logic        sys_wr_i,
	input wire logic [19:0] sys_addr_i,
	input wire logic        cpu_rd_i,
	input wire logic [15:0] cpu_addr_i,
	input wire logic        flag_irq_o,
	input wire logic        sys_irq_i,
	input wire logic        sys_irq_set_i,
	input wire logic        sys_irq_clr_i,
	input wire logic        sys_irq_o,
	input wire logic        cpu_trap_o
);
	// Mailbox write and read decode
	wire hit = sys_wr_i && sys_addr_i == board_base_i;
	wire rd  = cpu_rd_i && cpu_addr_i == `BIF_CPU_RAM_BASE;

	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);

	AST_FLAG_SET: assert property (hit |=> flag_irq_o)
		else $error("flag not set");
	AST_FLAG_CLR: assert property (rd && !hit |=> !flag_irq_o)
		else $error("flag not cleared");
	AST_FLAG_HOLD: assert property (flag_irq_o && !rd |=> flag_irq_o)
		else $error("flag lost");
	AST_NO_REQ: assert property (chan_req_i == 8'h00 |=> !general_irq_input_o)
		else $error("request without level");
	AST_ACK_TAKES: assert property (pr_ack_i && general_irq_input_o
		&& !pr_eoi_i && !pr_cfg_wr_i |=> ##1 !general_irq_input_o) else $error("ack ignored");
	AST_BUS_SET: assert property (sys_irq_set_i |=> sys_irq_o)
		else $error("bus irq not set");
	AST_BUS_CLR: assert property (sys_irq_clr_i && !sys_irq_set_i |=> !sys_irq_o)
		else $error("bus irq not cleared");
	AST_TRAP: assert property (!$past(srst_i) |-> cpu_trap_o == $past(sys_irq_i))
		else $error("trap not following");
endmodule

bind bif_top bif_chk u_chk (.sys_clk_i, .srst_i, .chan_req_i, .pr_cfg_wr_i, .pr_ack_i,
	.pr_eoi_i, .general_irq_input_o, .board_base_i, .sys_wr_i, .sys_addr_i, .cpu_rd_i,
	.cpu_addr_i, .flag_irq_o, .sys_irq_i, .sys_irq_set_i, .sys_irq_clr_i, .sys_irq_o,
	.cpu_trap_o);
`default_nettype wire

// ---- verification/bif_cpu_model.sv ----
// Processor model that services funnel requests
`timescale 1ns/1ps
`default_nettype none

module bif_cpu_model (
	input  wire logic clk_i,
	input  wire logic srst_i,
	input  wire logic irq_i,
	output var  logic ack_o,
	output var  logic eoi_o
);
	logic [1:0] cnt_q;

	// Ack a raised request, end service three cycles on
	always @(posedge clk_i) begin
		if (srst_i) begin
			cnt_q <= 2'h0;
			ack_o <= 1'b0;
			eoi_o <= 1'b0;
		end else begin
			ack_o <= (cnt_q == 2'h0) && irq_i && !ack_o;
			eoi_o <= (cnt_q == 2'h1);
			if (cnt_q != 2'h0) begin
				cnt_q <= cnt_q - 2'h1;
			end else if (irq_i && !ack_o) begin
				cnt_q <= 2'h3;
			end
		end
	end
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// Bench for the interrupt funnel
`timescale 1ns/1ps
`default_nettype none
`include "bif_defs.vh"

module tb;
	logic        sys_clk_i, srst_i, pr_cfg_wr_i, sys_wr_i, cpu_rd_i, line_clr_i;
	logic        timer6_i, sys_irq_i, sys_irq_set_i, sys_irq_clr_i, cpu_mask_wr_i;
	logic [7:0]  chan_req_i, pr_mask_i;
	logic [1:0]  pr_mode_i;
	logic [2:0]  pr_lowest_i;
	logic [19:0] board_base_i, sys_addr_i;
	logic [15:0] cpu_addr_i;
	logic [3:0]  carrier_i, ring_i, carrier_clr_i, ring_clr_i, cpu_mask_i;
	wire         pr_ack_i, pr_eoi_i, general_irq_input_o, flag_irq_o, sys_irq_o;
	wire         cpu_trap_o, cpu_r75_o, cpu_r65_o, cpu_r55_o, cpu_gen_o;
	wire [2:0]   pr_level_o;
	wire [3:0]   carrier_lost_o, ring_seen_o;
	wire [15:0]  cpu_vec_o;
	integer      err_total = 0;
	integer      n_tests = 0;

	bif_top dut (.*);
	bif_cpu_model cpu (.clk_i(sys_clk_i), .srst_i(srst_i), .irq_i(general_irq_input_o),
		.ack_o(pr_ack_i), .eoi_o(pr_eoi_i));

	always #20 sys_clk_i = ~sys_clk_i;

	task tally_and_finish;
		$display("mismatches %0d of %0d checks", err_total, n_tests);
		if (err_total == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	task chk(input logic [31:0] s, input logic [31:0] e);
		n_tests = n_tests + 1;
		if (s !== e) begin
			err_total = err_total + 1;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	// Next ack from the processor model, bounded
	task wait_ack;
		integer i;
		@(posedge sys_clk_i);
		#1;
		for (i = 0; i < 40 && pr_ack_i !== 1'b1; i = i + 1) begin
			@(posedge sys_clk_i);
			#1;
		end
		if (pr_ack_i !== 1'b1) begin
			err_total = err_total + 1;
			tally_and_finish;
		end
	endtask

	// Drain, then load mode and mask, and lowest when the mode is specific
	task cfg(input logic [1:0] m, input logic [2:0] l);
		@(posedge sys_clk_i);
		chan_req_i <= 8'h00;
		repeat (6) @(posedge sys_clk_i);
		pr_mode_i <= m;
		pr_lowest_i <= l;
		pr_cfg_wr_i <= 1'b1;
		@(posedge sys_clk_i);
		pr_cfg_wr_i <= 1'b0;
	endtask

	// Three serviced levels in a row
	task run3(input logic [7:0] r, input logic [2:0] a, b, c);
		@(posedge sys_clk_i);
		chan_req_i <= r;
		wait_ack;
		chk(pr_level_o, a);
		wait_ack;
		chk(pr_level_o, b);
		wait_ack;
		chk(pr_level_o, c);
	endtask

	task t_pri;
		run3(8'h88, 3'h3, 3'h3, 3'h3);
		cfg(`BIF_MODE_ROTATE, 3'h7);
		run3(8'hff, 3'h0, 3'h1, 3'h2);
		cfg(`BIF_MODE_SPECIFIC, 3'h4);
		run3(8'h09, 3'h0, 3'h0, 3'h0);
		cfg(`BIF_MODE_SPECIFIC, 3'h2);
		run3(8'h09, 3'h3, 3'h3, 3'h3);
		// Masked level 0 must never win
		pr_mask_i <= 8'h01;
		cfg(`BIF_MODE_NESTED, 3'h7);
		run3(8'h03, 3'h1, 3'h1, 3'h1);
	endtask

	task t_mail;
		@(posedge sys_clk_i);
		sys_addr_i <= 20'h1d000;
		sys_wr_i <= 1'b1;
		@(posedge sys_clk_i);
		sys_addr_i <= 20'h1c000;
		#1 chk(flag_irq_o, 1'b0);
		@(posedge sys_clk_i);
		sys_wr_i <= 1'b0;
		cpu_addr_i <= `BIF_CPU_RAM_BASE;
		#1 chk(flag_irq_o, 1'b1);
		repeat (3) @(posedge sys_clk_i);
		#1 chk(cpu_vec_o, `BIF_VEC_R65);
		chk(cpu_r65_o, 1'b1);
		@(posedge sys_clk_i);
		cpu_rd_i <= 1'b1;
		@(posedge sys_clk_i);
		cpu_rd_i <= 1'b0;
		#1 chk(flag_irq_o, 1'b0);
	endtask

	task t_bus;
		@(posedge sys_clk_i);
		{sys_irq_set_i, sys_irq_i, timer6_i, cpu_mask_wr_i} <= 4'hf;
		cpu_mask_i <= 4'hf;
		@(posedge sys_clk_i);
		{sys_irq_set_i, cpu_mask_wr_i} <= 2'h0;
		#1 chk(sys_irq_o, 1'b1);
		repeat (3) @(posedge sys_clk_i);
		#1 chk({cpu_trap_o, cpu_r75_o, cpu_gen_o, cpu_vec_o}, {3'h4, `BIF_VEC_TRAP});
		@(posedge sys_clk_i);
		{sys_irq_clr_i, cpu_mask_wr_i, sys_irq_i} <= 3'h6;
		cpu_mask_i <= 4'h0;
		carrier_i <= 4'hb;
		ring_i <= 4'h2;
		@(posedge sys_clk_i);
		{sys_irq_clr_i, cpu_mask_wr_i} <= 2'h0;
		#1 chk(sys_irq_o, 1'b0);
		repeat (3) @(posedge sys_clk_i);
		#1 chk(cpu_vec_o, `BIF_VEC_R75);
		chk({carrier_lost_o, ring_seen_o}, 8'h42);
		chk(cpu_r55_o, 1'b1);
		@(posedge sys_clk_i);
		{line_clr_i, carrier_clr_i, ring_clr_i} <= 9'h142;
		@(posedge sys_clk_i);
		line_clr_i <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		#1 chk({carrier_lost_o, ring_seen_o}, 8'h00);
	endtask

	// Reset for four cycles, then the scenarios
	initial begin
		{sys_clk_i, pr_cfg_wr_i, sys_wr_i, cpu_rd_i, line_clr_i, timer6_i} = 6'h0;
		{sys_irq_i, sys_irq_set_i, sys_irq_clr_i, cpu_mask_wr_i, ring_i} = 8'h0;
		{chan_req_i, pr_mask_i, pr_mode_i, pr_lowest_i, sys_addr_i, cpu_addr_i} = 57'h0;
		{carrier_clr_i, ring_clr_i, cpu_mask_i} = 12'h0;
		carrier_i = 4'hf;
		board_base_i = 20'h1c000;
		srst_i = 1'b1;
		repeat (4) @(posedge sys_clk_i);
		srst_i <= 1'b0;
		#1 chk({flag_irq_o, sys_irq_o, general_irq_input_o}, 3'h0);
		t_pri;
		t_mail;
		t_bus;
		tally_and_finish;
	end
endmodule
`default_nettype wire
